/* File: core/xrx_defines.svh */
// Purpose: named constants for the xor and return execution block
// Assumes: 14-bit instruction words, 8-bit data path
// Notes: timing constants derive the clocks per quarter from the clock rate
`ifndef XRX_DEFINES_SVH
`define XRX_DEFINES_SVH

// ***********************************
// opcode fields
// ***********************************
`define XRX_OP_XOR_LITERAL_INTO_ACC 6'h3A
`define XRX_OP_XOR_ACC_WITH_FILE_REG 6'h06
`define XRX_OP_RETURN_WITH_LITERAL 4'hD
`define XRX_DEST_BIT 7
`define XRX_ADDR_MSB 6

// ***********************************
// timing
// ***********************************
`define XRX_CLK_NS 25
`define XRX_TCY_MIN_NS 200
`define XRX_QUARTERS 4
// clocks per quarter: minimum cycle time rounded up over four quarters
`define XRX_QTR_CLKS ((`XRX_TCY_MIN_NS + `XRX_QUARTERS * `XRX_CLK_NS - 1) / (`XRX_QUARTERS * `XRX_CLK_NS))
`define XRX_ACC_RST 8'h00

`endif

/* File: core/xrx_pkg.sv */
// Purpose: types for the xor and return execution block
// Assumes: included defines hold all numbers
// Notes: quarter states are Gray coded
package xrx_pkg;
    typedef enum logic [1:0] {
        XRX_Q1 = 2'h0,
        XRX_Q2 = 2'h1,
        XRX_Q3 = 2'h3,
        XRX_Q4 = 2'h2
    } xrx_qtr_e;
    typedef logic [13:0] xrx_insn_t;
    typedef logic [7:0] xrx_byte_t;
    typedef logic [12:0] xrx_pc_t;
endpackage

/* File: core/xrx_core.sv */
// Purpose: executes literal xor, register xor and return with literal
// Assumes: file register read data valid in the quarter after the address is shown
// Notes: one instruction cycle is four quarters; return takes two cycles
`include "xrx_defines.svh"

module xrx_core #(
    parameter int QTR_CLKS = `XRX_QTR_CLKS
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic RSTN,
    // program memory
    input wire xrx_pkg::xrx_insn_t INSN,
    output logic INSN_REQ,
    // stack
    input wire xrx_pkg::xrx_pc_t TOP_OF_STACK,
    output logic STACK_POP,
    output xrx_pkg::xrx_pc_t PC,
    // file register
    output logic [6:0] FILE_ADDR,
    input wire xrx_pkg::xrx_byte_t FILE_RDATA,
    output xrx_pkg::xrx_byte_t FILE_WDATA,
    output logic FILE_WE,
    // core state
    output xrx_pkg::xrx_byte_t ACC,
    output logic ZERO_FLAG,
    output logic [1:0] QUARTER
);
    import xrx_pkg::*;

    localparam int CW = $clog2(QTR_CLKS + 1);

    xrx_qtr_e qtr;
    logic [CW-1:0] qcnt;
    logic qtr_end;
    logic nop_cycle;
    xrx_insn_t ir;
    xrx_byte_t operand;
    xrx_byte_t result;
    logic is_xor_lit;
    logic is_xor_reg;
    logic is_ret_lit;
    logic [12:0] next_pc;

    // decode helpers, shared by several processes
    function automatic logic dec_xor_lit(input xrx_insn_t w);
        return w[13:8] == `XRX_OP_XOR_LITERAL_INTO_ACC;
    endfunction
    function automatic logic dec_xor_reg(input xrx_insn_t w);
        return w[13:8] == `XRX_OP_XOR_ACC_WITH_FILE_REG;
    endfunction
    // the two low opcode bits of a return are don't-care
    function automatic logic dec_ret_lit(input xrx_insn_t w);
        return w[13:10] == `XRX_OP_RETURN_WITH_LITERAL;
    endfunction

    // ***********************************
    // quarter sequencer
    // ***********************************
    assign qtr_end = (qcnt == CW'(QTR_CLKS - 1));

    // quarter stretched over several clocks so a cycle never beats 200 ns
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            qcnt <= '0;
        end else if (qtr_end) begin
            qcnt <= '0;
        end else begin
            qcnt <= qcnt + CW'(1);
        end
    end

    // gray walk Q1 Q2 Q3 Q4
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            qtr <= XRX_Q1;
        end else if (qtr_end) begin
            case (qtr)
                XRX_Q1: qtr <= XRX_Q2;
                XRX_Q2: qtr <= XRX_Q3;
                XRX_Q3: qtr <= XRX_Q4;
                XRX_Q4: qtr <= XRX_Q1;
                default: qtr <= XRX_Q1;
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            QUARTER <= 2'h0;
        end else begin
            QUARTER <= qtr;
        end
    end

    // ***********************************
    // fetch and decode
    // ***********************************
    assign is_xor_lit = dec_xor_lit(ir) && !nop_cycle;
    assign is_xor_reg = dec_xor_reg(ir) && !nop_cycle;
    assign is_ret_lit = dec_ret_lit(ir) && !nop_cycle;

    // fetch request pulses once at the start of Q1, in the idle cycle too
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            INSN_REQ <= 1'b0;
        end else begin
            INSN_REQ <= qtr == XRX_Q4 && qtr_end;
        end
    end

    // instruction latched at the end of Q1 (decode)
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            ir <= '0;
        end else if (qtr == XRX_Q1 && qtr_end) begin
            ir <= INSN;
        end
    end

    // second cycle of return is a forced no-operation
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            nop_cycle <= 1'b0;
        end else if (qtr == XRX_Q4 && qtr_end) begin
            nop_cycle <= is_ret_lit;
        end
    end

    // ***********************************
    // read and process
    // ***********************************
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            FILE_ADDR <= 7'h00;
        end else if (qtr == XRX_Q1 && qtr_end) begin
            FILE_ADDR <= INSN[`XRX_ADDR_MSB:0];
        end
    end

    // Q2 read: literal field or file register data
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            operand <= 8'h00;
        end else if (qtr == XRX_Q2 && qtr_end) begin
            operand <= is_xor_reg ? FILE_RDATA : ir[7:0];
        end
    end

    // Q3 process
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            result <= 8'h00;
        end else if (qtr == XRX_Q3 && qtr_end) begin
            result <= is_ret_lit ? operand : (ACC ^ operand);
        end
    end

    // ***********************************
    // write back
    // ***********************************
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            ACC <= `XRX_ACC_RST;
        end else if (qtr == XRX_Q4 && qtr_end) begin
            if (is_xor_lit || is_ret_lit || (is_xor_reg && !ir[`XRX_DEST_BIT])) begin
                ACC <= result;
            end
        end
    end

    // register destination only when the d bit is set
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            FILE_WE <= 1'b0;
            FILE_WDATA <= 8'h00;
        end else begin
            FILE_WE <= qtr == XRX_Q4 && qtr_end && is_xor_reg && ir[`XRX_DEST_BIT];
            FILE_WDATA <= result;
        end
    end

    // zero flag only touched by the xor forms
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            ZERO_FLAG <= 1'b0;
        end else if (qtr == XRX_Q4 && qtr_end && (is_xor_lit || is_xor_reg)) begin
            ZERO_FLAG <= result == 8'h00;
        end
    end

    // ***********************************
    // program counter and stack
    // ***********************************
    assign next_pc = is_ret_lit ? TOP_OF_STACK : PC + 13'h0001;

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            PC <= 13'h0000;
            STACK_POP <= 1'b0;
        end else begin
            STACK_POP <= qtr == XRX_Q4 && qtr_end && is_ret_lit;
            if (qtr == XRX_Q4 && qtr_end) begin
                PC <= nop_cycle ? PC : next_pc;
            end
        end
    end

    // ***********************************
    // checks
    // ***********************************
    sequence s_ret_pop;
        STACK_POP ##1 (QUARTER == 2'h0);
    endsequence

    a_xor_lit_acc: assert property (@(posedge MCLK) disable iff (!RSTN)
        (qtr == XRX_Q4 && qtr_end && is_xor_lit) |=> ACC == $past(result))
        else $error("literal xor did not reach accumulator");
    a_xor_reg_keep: assert property (@(posedge MCLK) disable iff (!RSTN)
        (qtr == XRX_Q4 && qtr_end && is_xor_reg && !ir[`XRX_DEST_BIT])
        |=> !FILE_WE && ACC == $past(result))
        else $error("register xor to accumulator misbehaved");
    a_xor_reg_file: assert property (@(posedge MCLK) disable iff (!RSTN)
        FILE_WE |-> $stable(ACC) && FILE_WDATA == $past(result))
        else $error("register xor write back wrong");
    a_ret_pop: assert property (@(posedge MCLK) disable iff (!RSTN)
        s_ret_pop |-> nop_cycle && PC == $past(TOP_OF_STACK, 2))
        else $error("return did not pop into pc");
    a_ret_idle: assert property (@(posedge MCLK) disable iff (!RSTN)
        (nop_cycle && qtr == XRX_Q4 && qtr_end) |=> $stable(ACC) && !STACK_POP)
        else $error("idle cycle after return did work");
    a_qtr_len: assert property (@(posedge MCLK) disable iff (!RSTN)
        $rose(INSN_REQ) |-> ##1 !INSN_REQ [*7])
        else $error("instruction cycle shorter than eight clocks");
    a_zero_set: assert property (@(posedge MCLK) disable iff (!RSTN)
        (qtr == XRX_Q4 && qtr_end && (is_xor_lit || is_xor_reg))
        |=> ZERO_FLAG == ($past(result) == 8'h00))
        else $error("zero flag wrong after xor");
    a_zero_hold: assert property (@(posedge MCLK) disable iff (!RSTN)
        STACK_POP |-> $stable(ZERO_FLAG))
        else $error("return changed zero flag");
endmodule

/* File: verif/xrx_far_model.sv */
// Purpose: program memory, return stack and file register on the far side of the core
// Assumes: fetch follows the program counter, file read is combinational
// Notes: after a pop the stack shows an inverted address, so a late read is caught
module xrx_far_model (
    // clock
    input wire logic MCLK,
    // program memory
    input wire xrx_pkg::xrx_pc_t PC,
    output xrx_pkg::xrx_insn_t INSN,
    // stack
    input wire logic STACK_POP,
    output xrx_pkg::xrx_pc_t TOP_OF_STACK,
    // file register
    input wire logic [6:0] FILE_ADDR,
    input wire logic FILE_WE,
    input wire xrx_pkg::xrx_byte_t FILE_WDATA,
    output xrx_pkg::xrx_byte_t FILE_RDATA
);
    import xrx_pkg::*;
    xrx_insn_t prog [0:127];
    xrx_byte_t regs [0:127];
    xrx_pc_t stack_word;
    // ************
    // storage
    // ************
    assign INSN = prog[PC[6:0]];
    assign TOP_OF_STACK = stack_word;
    assign FILE_RDATA = regs[FILE_ADDR];
    // file write and stack pop; no second level, popped slot is inverted
    always @(posedge MCLK) begin
        if (FILE_WE === 1'b1) begin
            regs[FILE_ADDR] <= FILE_WDATA;
        end
        if (STACK_POP === 1'b1) begin
            stack_word <= ~stack_word;
        end
    end
    // program under test; unused words are zero, an unknown opcode
    initial begin
        for (int i = 0; i < 128; i++) begin
            prog[i] = 14'h0000;
            regs[i] = 8'h00;
        end
        prog[0] = 14'h3AB5;
        prog[1] = 14'h3AB5;
        prog[2] = 14'h3AFF;
        prog[3] = 14'h0620;
        prog[4] = 14'h06A0;
        prog[5] = 14'h06A1;
        prog[6] = 14'h345A;
        prog[16] = 14'h3A0F;
        regs[32] = 8'hAF;
        regs[33] = 8'h50;
        stack_word = 13'h0010;
    end
endmodule

/* File: verif/xor_and_return_execution_tb_top.sv */
// Purpose: self-checking bench for the xor and return execution core
// Assumes: two clocks per quarter, eight clocks per instruction cycle
// Notes: results are judged just after the edge that starts the next cycle
module xor_and_return_execution_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import xrx_pkg::*;
    `define XRX_CHK(got, exp) \
        begin \
            comparisons++; \
            if ((got) !== (exp)) begin \
                failures++; \
                $display("[FAIL] %0t got %0h expected %0h", $time, got, exp); \
            end \
        end
    logic MCLK = 1'b0;
    logic RSTN = 1'b0;
    xrx_insn_t INSN;
    logic INSN_REQ;
    xrx_pc_t TOP_OF_STACK;
    logic STACK_POP;
    xrx_pc_t PC;
    logic [6:0] FILE_ADDR;
    xrx_byte_t FILE_RDATA;
    xrx_byte_t FILE_WDATA;
    logic FILE_WE;
    xrx_byte_t ACC;
    logic ZERO_FLAG;
    logic [1:0] QUARTER;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    int we_count = 0;
    int pop_count = 0;
    // ************
    // clock, watchdog and pulse counters
    // ************
    always #12.5 MCLK = ~MCLK;
    // a hang stops here rather than running forever
    always @(posedge MCLK) begin
        cycles++;
        if (FILE_WE === 1'b1) we_count++;
        if (STACK_POP === 1'b1) pop_count++;
        if (cycles == 2000) begin
            failures++;
            report_and_stop();
        end
    end
    xrx_core #(.QTR_CLKS(2)) i_xrx_core (
        .MCLK(MCLK), .RSTN(RSTN), .INSN(INSN), .INSN_REQ(INSN_REQ),
        .TOP_OF_STACK(TOP_OF_STACK), .STACK_POP(STACK_POP), .PC(PC),
        .FILE_ADDR(FILE_ADDR), .FILE_RDATA(FILE_RDATA), .FILE_WDATA(FILE_WDATA),
        .FILE_WE(FILE_WE), .ACC(ACC), .ZERO_FLAG(ZERO_FLAG), .QUARTER(QUARTER)
    );
    xrx_far_model i_xrx_far_model (
        .MCLK(MCLK), .PC(PC), .INSN(INSN), .STACK_POP(STACK_POP),
        .TOP_OF_STACK(TOP_OF_STACK), .FILE_ADDR(FILE_ADDR), .FILE_WE(FILE_WE),
        .FILE_WDATA(FILE_WDATA), .FILE_RDATA(FILE_RDATA)
    );
    // ************
    // scenarios
    // ************
    task next_cyc;
        @(posedge INSN_REQ);
        #1;
    endtask
    // literal xor, zero flag both ways, quarter structure of one cycle
    task t_literal;
        time t0;
        int n2;
        int n4;
        int nreq;
        n2 = 0;
        n4 = 0;
        nreq = 0;
        // first word has finished when the first fetch request rises
        next_cyc;
        t0 = $time;
        `XRX_CHK(ACC, 8'hB5)
        `XRX_CHK(ZERO_FLAG, 1'b0)
        `XRX_CHK(PC, 13'h0001)
        for (int i = 0; i < 8; i++) begin
            if (QUARTER === XRX_Q2) n2++;
            if (QUARTER === XRX_Q4) n4++;
            if (INSN_REQ === 1'b1) nreq++;
            if (i < 7) @(posedge MCLK);
            #1;
        end
        `XRX_CHK(n2, 2)
        `XRX_CHK(n4, 2)
        `XRX_CHK(nreq, 1)
        next_cyc;
        `XRX_CHK($time - t0, 64'd200)
        `XRX_CHK(ACC, 8'h00)
        `XRX_CHK(ZERO_FLAG, 1'b1)
        next_cyc;
        `XRX_CHK(ACC, 8'hFF)
        `XRX_CHK(ZERO_FLAG, 1'b0)
    endtask
    // register xor into accumulator, then back into file registers 32 and 33
    task t_file;
        next_cyc;
        `XRX_CHK(ACC, 8'h50)
        `XRX_CHK(ZERO_FLAG, 1'b0)
        next_cyc;
        `XRX_CHK(we_count, 0)
        `XRX_CHK(FILE_WE, 1'b1)
        `XRX_CHK(FILE_ADDR, 7'h20)
        `XRX_CHK(FILE_WDATA, 8'hFF)
        `XRX_CHK(ACC, 8'h50)
        next_cyc;
        `XRX_CHK(i_xrx_far_model.regs[32], 8'hFF)
        `XRX_CHK(FILE_WDATA, 8'h00)
        `XRX_CHK(ZERO_FLAG, 1'b1)
    endtask
    // return with literal, idle cycle, then the instruction at the return address
    task t_return;
        next_cyc;
        `XRX_CHK(ACC, 8'h5A)
        `XRX_CHK(PC, 13'h0010)
        `XRX_CHK(STACK_POP, 1'b1)
        `XRX_CHK(ZERO_FLAG, 1'b1)
        next_cyc;
        `XRX_CHK(ACC, 8'h5A)
        `XRX_CHK(PC, 13'h0010)
        `XRX_CHK(pop_count, 1)
        next_cyc;
        `XRX_CHK(ACC, 8'h55)
        `XRX_CHK(i_xrx_far_model.regs[33], 8'h00)
    endtask
    task report_and_stop;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // reset for ten clocks, then run the program
    initial begin
        repeat (10) @(posedge MCLK);
        RSTN <= 1'b1;
        t_literal;
        t_file;
        t_return;
        report_and_stop;
    end
endmodule
